// ---- design/gpa_port.sv ----
// eight-bit general purpose port with analog, comparator and oscillator sharing
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module gpa_port
(
  input  wire logic                          I_MCLK,
  input  wire logic                          I_RSTN,
  input  wire logic                          I_HSEL,
  input  wire logic [31:0]                   I_HADDR,
  input  wire logic [1:0]                    I_HTRANS,
  input  wire logic                          I_HWRITE,
  input  wire logic [2:0]                    I_HSIZE,
  input  wire logic [31:0]                   I_HWDATA,
  input  wire logic                          I_HREADY,
  output var  logic [31:0]                   O_HRDATA,
  output var  logic                          O_HREADYOUT,
  output var  logic                          O_HRESP,
  input  wire logic [gpa_pkg::PORT_WIDTH-1:0] I_PAD_IN,
  output var  logic [gpa_pkg::PORT_WIDTH-1:0] O_PAD_OUT,
  output var  logic [gpa_pkg::PORT_WIDTH-1:0] O_PAD_OE_N,
  input  wire logic                          I_CMP1_OUT,
  input  wire logic                          I_CMP2_OUT,
  output var  logic                          O_TMR0_CLK,
  output var  logic [gpa_pkg::PORT_WIDTH-1:0] O_ANALOG_SEL,
  output var  logic [gpa_pkg::CMP_WIDTH-1:0]  O_CMP_CTRL
);
  import gpa_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] addr,
                                   input logic [ADDR_WIDTH-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // analog map: adc bits 0-3 to pins 0-3, adc bit 4 to pin 5
  function automatic logic [PORT_WIDTH-1:0] analog_mask(input logic [ADC_SEL_WIDTH-1:0] adc,
                                                        input logic cmp_on);
    analog_mask = {2'h0, adc[4], 1'b0, adc[3:0] | {4{cmp_on}}};
  endfunction

  // ==========================================================
  // state
  gpa_bus_t                  state;
  logic [ADDR_WIDTH-1:0]     addr_q;
  logic [PORT_WIDTH-1:0]     dir_reg;
  logic [PORT_WIDTH-1:0]     lat_reg;
  logic [ADC_SEL_WIDTH-1:0]  adc_reg;
  logic [CMP_WIDTH-1:0]      cmp_reg;
  logic                      osc_reg;
  logic [PORT_WIDTH-1:0]     sync1;
  logic [PORT_WIDTH-1:0]     sync2;
  logic [PORT_WIDTH-1:0]     osc_mask;
  logic [PORT_WIDTH-1:0]     analog;
  logic [PORT_WIDTH-1:0]     pin_level;
  logic [PORT_WIDTH-1:0]     next_pad_out;
  logic [PORT_WIDTH-1:0]     next_pad_oe_n;
  logic [31:0]               read_mux;
  logic                      addr_ok;
  logic                      wr_en;

  assign addr_ok  = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign wr_en    = (state == BS_WRITE);
  assign osc_mask = {{2{osc_reg}}, 6'h00};
  assign analog   = analog_mask(adc_reg, cmp_reg[CMP_ON_BIT]);

  // ==========================================================
  // bus slave: writes zero wait, reads one wait state
  // the read wait lets a write just before a read land first
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      state       <= BS_IDLE;
      addr_q      <= '0;
      O_HREADYOUT <= 1'b1;
      O_HRDATA    <= 32'h0000_0000;
    end
    else
    begin
      unique case (state)
        BS_IDLE, BS_WRITE:
        begin
          if (addr_ok)
          begin
            addr_q <= I_HADDR[ADDR_WIDTH-1:0];
            if (I_HWRITE)
            begin
              state <= BS_WRITE;
            end
            else
            begin
              state       <= BS_RDWAIT;
              O_HREADYOUT <= 1'b0;
            end
          end
          else
          begin
            state <= BS_IDLE;
          end
        end
        BS_RDWAIT:
        begin
          O_HRDATA    <= read_mux;
          O_HREADYOUT <= 1'b1;
          state       <= BS_IDLE;
        end
        // spare code: fall back to idle with the bus ready
        default:
        begin
          O_HREADYOUT <= 1'b1;
          state       <= BS_IDLE;
        end
      endcase
    end
  end

  // never an error; unmapped addresses read zero
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_HRESP <= 1'b0;
    end
    else
    begin
      O_HRESP <= 1'b0;
    end
  end

  // ==========================================================
  // software registers
  // two port registers; the pin and latch offsets both write the latch
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      dir_reg <= RST_DIR;
      lat_reg <= RST_LAT;
    end
    else if (wr_en)
    begin
      if (reg_hit(addr_q, OFS_DIR))
      begin
        dir_reg <= I_HWDATA[PORT_WIDTH-1:0];
      end
      if (reg_hit(addr_q, OFS_PIN) || reg_hit(addr_q, OFS_LAT))
      begin
        lat_reg <= I_HWDATA[PORT_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      adc_reg <= RST_ADC;
      cmp_reg <= RST_CMP;
      osc_reg <= RST_OSC;
    end
    else if (wr_en)
    begin
      if (reg_hit(addr_q, OFS_ADC))
      begin
        adc_reg <= I_HWDATA[ADC_SEL_WIDTH-1:0];
      end
      if (reg_hit(addr_q, OFS_CMP))
      begin
        cmp_reg <= I_HWDATA[CMP_WIDTH-1:0];
      end
      if (reg_hit(addr_q, OFS_OSC))
      begin
        osc_reg <= I_HWDATA[OSC_ON_BIT];
      end
    end
  end

  always_comb
  begin
    read_mux = 32'h0000_0000;
    unique case (1'b1)
      reg_hit(addr_q, OFS_DIR): read_mux[PORT_WIDTH-1:0] = dir_reg & ~osc_mask;
      reg_hit(addr_q, OFS_PIN): read_mux[PORT_WIDTH-1:0] = pin_level;
      reg_hit(addr_q, OFS_LAT): read_mux[PORT_WIDTH-1:0] = lat_reg & ~osc_mask;
      reg_hit(addr_q, OFS_ADC): read_mux[ADC_SEL_WIDTH-1:0] = adc_reg;
      reg_hit(addr_q, OFS_CMP): read_mux[CMP_WIDTH-1:0] = cmp_reg;
      reg_hit(addr_q, OFS_OSC): read_mux[OSC_ON_BIT] = osc_reg;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // pin sampling
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= I_PAD_IN;
      sync2 <= sync1;
    end
  end

  assign pin_level = sync2 & ~analog & ~osc_mask;

  // ==========================================================
  // pin drivers
  // eight independent pins
  for (genvar i = 0; i < PORT_WIDTH; i++)
  begin : g_pin
    logic osc_pin;
    logic per_drive;
    logic per_val;
    assign osc_pin   = (i >= PIN_OSC_LO) && osc_reg;
    assign per_drive = (i == PIN_TMR_CMP1) ? cmp_reg[CMP_C1OE_BIT] :
                       (i == PIN_CMP2)     ? cmp_reg[CMP_C2OE_BIT] : 1'b0;
    assign per_val   = (i == PIN_TMR_CMP1) ? I_CMP1_OUT : I_CMP2_OUT;
    assign next_pad_oe_n[i] = osc_pin ? 1'b1 : (per_drive ? 1'b0 : dir_reg[i]);
    assign next_pad_out[i]  = osc_pin ? 1'b0 : (per_drive ? per_val : lat_reg[i]);
  end

  // direction still governs analog pins, software keeps them input
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_PAD_OE_N   <= RST_DIR;
      O_PAD_OUT    <= RST_LAT;
      O_ANALOG_SEL <= analog_mask(RST_ADC, RST_CMP[CMP_ON_BIT]);
      O_CMP_CTRL   <= RST_CMP;
    end
    else
    begin
      O_PAD_OE_N   <= next_pad_oe_n;
      O_PAD_OUT    <= next_pad_out;
      O_ANALOG_SEL <= analog;
      O_CMP_CTRL   <= cmp_reg;
    end
  end

  assign O_TMR0_CLK = sync2[PIN_TMR_CMP1];

  // ==========================================================
  // checks
  a_dir_input_hiz: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    dir_reg[0] |=> O_PAD_OE_N[0])
    else $error("input pin is driven");

  a_drive_from_latch: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    !dir_reg[1] |=> (!O_PAD_OE_N[1] && O_PAD_OUT[1] == $past(lat_reg[1])))
    else $error("output pin does not carry latch");

  a_pin_read_value: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == BS_RDWAIT && addr_q == OFS_PIN) |=> O_HRDATA[7:0] == $past(pin_level))
    else $error("level read wrong");

  a_level_write_latch: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == BS_WRITE && addr_q == OFS_PIN) ##1 !dir_reg[2] && !osc_reg
      |=> O_PAD_OUT[2] == $past(I_HWDATA[2], 2))
    else $error("level write did not reach pin");

  a_latch_readback: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == BS_RDWAIT && addr_q == OFS_LAT && !osc_reg) |=> O_HRDATA[7:0] == $past(lat_reg))
    else $error("latch read wrong");

  a_cmp_owns_pin: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    cmp_reg[CMP_C1OE_BIT] |=> (!O_PAD_OE_N[4] && O_PAD_OUT[4] == $past(I_CMP1_OUT)))
    else $error("comparator output not on pin");

  a_timer_clock_path: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    $past(I_RSTN, 3) |-> O_TMR0_CLK == $past(I_PAD_IN[4], 2))
    else $error("timer clock path wrong");

  a_osc_read_zero: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == BS_RDWAIT && osc_reg && addr_q <= OFS_LAT) |=> O_HRDATA[7:6] == 2'b00)
    else $error("oscillator bits not zero");

  a_osc_driver_off: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    osc_reg |=> O_PAD_OE_N[7:6] == 2'b11)
    else $error("oscillator pin driven");

  a_adc_select: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == BS_WRITE && addr_q == OFS_ADC) ##1 !cmp_reg[CMP_ON_BIT]
      |=> O_ANALOG_SEL[3:0] == $past(I_HWDATA[3:0], 2))
    else $error("adc selection not applied");

  a_cmp_analog: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    cmp_reg[CMP_ON_BIT] |=> O_ANALOG_SEL[3:0] == 4'hF)
    else $error("comparator pins not analog");

  a_reset_config: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    $rose(I_RSTN) |-> (dir_reg == RST_DIR && adc_reg == RST_ADC && !O_ANALOG_SEL[4]))
    else $error("reset configuration wrong");

  a_analog_reads_zero: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == BS_RDWAIT && addr_q == OFS_PIN && analog[0]) |=> !O_HRDATA[0])
    else $error("analog pin read nonzero");

  c_pin_read: cover property (@(posedge I_MCLK) disable iff (!I_RSTN)
    state == BS_RDWAIT && addr_q == OFS_PIN);
  c_latch_write: cover property (@(posedge I_MCLK) disable iff (!I_RSTN)
    state == BS_WRITE && addr_q == OFS_LAT);
  c_osc_mode: cover property (@(posedge I_MCLK) disable iff (!I_RSTN)
    osc_reg && state == BS_RDWAIT);
  c_cmp_drive: cover property (@(posedge I_MCLK) disable iff (!I_RSTN)
    cmp_reg[CMP_C1OE_BIT] && !O_PAD_OE_N[4]);

endmodule

`default_nettype wire

// ---- design/gpa_pkg.sv ----
// constants and types shared by the general purpose port block
package gpa_pkg;
  // ==========================================================
  // port geometry
  localparam int unsigned PORT_WIDTH    = 8;
  localparam int unsigned PIN_TMR_CMP1  = 4;
  localparam int unsigned PIN_CMP2      = 5;
  localparam int unsigned PIN_OSC_LO    = 6;
  localparam int unsigned ADC_SEL_WIDTH = 5;
  localparam int unsigned CMP_WIDTH     = 3;
  localparam int unsigned ADDR_WIDTH    = 12;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFS_DIR = 12'h000;
  localparam logic [11:0] OFS_PIN = 12'h004;
  localparam logic [11:0] OFS_LAT = 12'h008;
  localparam logic [11:0] OFS_ADC = 12'h00C;
  localparam logic [11:0] OFS_CMP = 12'h010;
  localparam logic [11:0] OFS_OSC = 12'h014;

  // ==========================================================
  // field positions
  localparam int unsigned CMP_ON_BIT   = 0;
  localparam int unsigned CMP_C1OE_BIT = 1;
  localparam int unsigned CMP_C2OE_BIT = 2;
  localparam int unsigned OSC_ON_BIT   = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_LAT = 8'h00;
  localparam logic [4:0] RST_ADC = 5'h1F;
  localparam logic [2:0] RST_CMP = 3'h0;
  localparam logic       RST_OSC = 1'b0;

  // ==========================================================
  // bus slave phases
  typedef enum logic [1:0] {
    BS_IDLE,
    BS_WRITE,
    BS_RDWAIT
  } gpa_bus_t;
endpackage

// ---- tb/gpa_board.sv ----
// board model: external drivers and pull-ups on the port pins
`timescale 1ns/1ns
`default_nettype none

module gpa_board
(
  input  wire logic [7:0] i_pad_out,
  input  wire logic [7:0] i_pad_oe_n,
  input  wire logic [7:0] i_drv_en,
  input  wire logic [7:0] i_drv_val,
  output var  logic [7:0] o_pad_in
);
  // ==========================================================
  // pin resolution
  // released pins take the external driver when it is enabled, else the pull-up level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!i_pad_oe_n[i])
        o_pad_in[i] = i_pad_out[i];
      else if (i_drv_en[i])
        o_pad_in[i] = i_drv_val[i];
      else
        o_pad_in[i] = 1'b1;
    end
  end
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the general purpose port
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import gpa_pkg::*;
  logic        mclk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        hresp;
  logic [7:0]  pad_in;
  logic [7:0]  pad_out;
  logic [7:0]  oe_n;
  logic        cmp1;
  logic        cmp2;
  logic        tmr;
  logic [7:0]  an_sel;
  logic [2:0]  cmp_ctrl;
  logic [7:0]  drv_en;
  logic [7:0]  drv_val;
  logic [31:0] tmp;
  int          errors;
  int          check_count;

  gpa_port DUT (.I_MCLK(mclk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hrdy), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
    .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out), .O_PAD_OE_N(oe_n), .I_CMP1_OUT(cmp1),
    .I_CMP2_OUT(cmp2), .O_TMR0_CLK(tmr), .O_ANALOG_SEL(an_sel), .O_CMP_CTRL(cmp_ctrl));

  gpa_board board (.i_pad_out(pad_out), .i_pad_oe_n(oe_n), .i_drv_en(drv_en),
    .i_drv_val(drv_val), .o_pad_in(pad_in));

  // ==========================================================
  // clock and watchdog
  always #2 mclk = ~mclk;

  // run needs well under 1000 cycles
  initial
  begin
    #20000;
    errors++;
    wrap_up();
  end

  // ==========================================================
  // tasks
  task automatic wrap_up();
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // entered at a rising edge; returns at the edge that ends the data phase
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hrdy !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hrdy !== 1'b1) @(posedge mclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, tmp);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    chk(nm, exp, v);
  endtask

  // pad outputs lag one edge, pin reads two flops
  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask

  // ==========================================================
  // tests
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cmp1 = 1'b0;
    cmp2 = 1'b0;
    drv_en = 8'hFF;
    drv_val = 8'hFF;
    errors = 0;
    check_count = 0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdc("dir", OFS_DIR, 32'hFF);
    rdc("lat", OFS_LAT, 32'h00);
    rdc("adc", OFS_ADC, 32'h1F);
    rdc("cmp", OFS_CMP, 32'h0);
    rdc("osc", OFS_OSC, 32'h0);
    chk("oe_n", 32'hFF, {24'h0, oe_n});
    chk("an_sel", 32'h2F, {24'h0, an_sel});
    rdc("pin", OFS_PIN, 32'hD0);
    chk("tmr", 32'h1, {31'h0, tmr});
    wr(OFS_PIN, 32'hA5);
    rdc("lat", OFS_LAT, 32'hA5);
    wr(OFS_LAT, 32'h3C);
    rdc("lat", OFS_LAT, 32'h3C);
    wr(OFS_ADC, 32'h0);
    wr(OFS_CMP, 32'h0);
    drv_val <= 8'h0F;
    settle();
    chk("an_sel", 32'h0, {24'h0, an_sel});
    rdc("pin", OFS_PIN, 32'h0F);
    rdc("lat", OFS_LAT, 32'h3C);
    wr(OFS_DIR, 32'h0);
    settle();
    chk("oe_n", 32'h0, {24'h0, oe_n});
    chk("pad_out", 32'h3C, {24'h0, pad_out});
    rdc("pin", OFS_PIN, 32'h3C);
    // level write while driving reaches the pins
    wr(OFS_PIN, 32'h5A);
    settle();
    chk("pad_out", 32'h5A, {24'h0, pad_out});
    rdc("lat", OFS_LAT, 32'h5A);
    wr(OFS_LAT, 32'hC3);
    wr(OFS_DIR, 32'hC0);
    wr(OFS_OSC, 32'h1);
    settle();
    rdc("osc", OFS_OSC, 32'h1);
    rdc("dir", OFS_DIR, 32'h00);
    rdc("lat", OFS_LAT, 32'h03);
    rdc("pin", OFS_PIN, 32'h03);
    chk("oe_n", 32'hC0, {24'h0, oe_n});
    wr(OFS_OSC, 32'h0);
    rdc("dir", OFS_DIR, 32'hC0);
    rdc("lat", OFS_LAT, 32'hC3);
    wr(OFS_DIR, 32'h0);
    wr(OFS_LAT, 32'h0);
    cmp1 <= 1'b1;
    wr(OFS_CMP, 32'h2);
    settle();
    chk("pad_out", 32'h10, {24'h0, pad_out});
    chk("cmp_ctrl", 32'h2, {29'h0, cmp_ctrl});
    cmp1 <= 1'b0;
    settle();
    chk("pad_out", 32'h00, {24'h0, pad_out});
    cmp2 <= 1'b1;
    wr(OFS_CMP, 32'h4);
    settle();
    chk("pad_out", 32'h20, {24'h0, pad_out});
    // analog pins stay inputs
    wr(OFS_DIR, 32'hFF);
    wr(OFS_CMP, 32'h1);
    drv_val <= 8'hFF;
    settle();
    chk("an_sel", 32'h0F, {24'h0, an_sel});
    rdc("pin", OFS_PIN, 32'hF0);
    drv_val <= 8'hEF;
    settle();
    chk("tmr", 32'h0, {31'h0, tmr});
    wr(OFS_CMP, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(OFS_ADC, 32'h1 << i);
      settle();
      tmp = 32'h1 << i;
      chk("an_sel", {26'h0, tmp[4], 1'b0, tmp[3:0]}, {24'h0, an_sel});
      rdc("adc", OFS_ADC, 32'h1 << i);
    end
    // undriven pins float to the pull-up level
    drv_en <= 8'h00;
    settle();
    rdc("pin", OFS_PIN, 32'hDF);
    chk("tmr", 32'h1, {31'h0, tmr});
    wr(12'h020, 32'hFFFFFFFF);
    rdc("unmapped", 12'h020, 32'h0);
    wrap_up();
  end
endmodule

`default_nettype wire
